// >>> src/ema_consts.svh
// Register offsets, field positions and reset values of the extended ALU
`ifndef EMA_CONSTS_SVH
`define EMA_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define EMA_REG_ACC    8'h00
`define EMA_REG_STATUS 8'h04
`define EMA_REG_ADDR   8'h08
`define EMA_REG_BANK   8'h0C
`define EMA_REG_CMD    8'h10
`define EMA_REG_MDATA  8'h14

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define EMA_ST_C       0
`define EMA_ST_AUX     1
`define EMA_ST_Z       2
`define EMA_ST_OVF     3
`define EMA_ST_SKIP    4
`define EMA_ST_MSB     4
`define EMA_CMD_OP     2:0
`define EMA_CMD_BITMD  3
`define EMA_CMD_BIT    6:4
`define EMA_CMD_BUSY   7
`define EMA_ADR_WORD   7:2
`define EMA_LANE0      0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define EMA_RST_BYTE   8'h00
`define EMA_RST_FLAGS  5'h0
`define EMA_RST_WORD   32'h0000_0000

`endif

// >>> src/ema_pkg.sv
// Types shared by the extended ALU datapath
package ema_pkg;
   typedef enum logic [2:0] {
      EMA_OP_ADD_CARRY_TO_ACC  = 3'b000,
      EMA_OP_ADD_CARRY_TO_MEM  = 3'b001,
      EMA_OP_ADD_TO_ACC        = 3'b010,
      EMA_OP_ADD_TO_MEM        = 3'b011,
      EMA_OP_AND_TO_ACC        = 3'b100,
      EMA_OP_AND_TO_MEM        = 3'b101,
      EMA_OP_CLEAR_BYTE_OR_BIT = 3'b110,
      EMA_OP_RESERVED          = 3'b111
   } ema_op_e;

   typedef enum logic {
      EMA_IDLE = 1'b0,
      EMA_EXEC = 1'b1
   } ema_state_e;
endpackage

// >>> src/ema_alu.sv
// Combinational adder, AND and clear unit with flag generation
module ema_alu
   import ema_pkg::*;
#(
   parameter int DW = 8
) (
   input  wire logic [DW-1:0] acc_i,
   input  wire logic [DW-1:0] mem_i,
   input  wire logic          carry_i,
   input  wire ema_op_e       op_i,
   input  wire logic          bit_mode_i,
   input  wire logic [2:0]    bit_i,
   output logic      [DW-1:0] result_o,
   output logic               c_o,
   output logic               aux_o,
   output logic               z_o,
   output logic               ovf_o,
   output logic               skip_o
);
   logic          cin;
   logic [DW:0]   sum;
   logic [4:0]    low;
   logic [DW-1:0] keep_mask;

   // ----------------------------------------------------------------------
   // Bit keep mask
   // ----------------------------------------------------------------------
   for (genvar g = 0; g < DW; g++) begin : g_mask
      assign keep_mask[g] = (bit_i != 3'(g));
   end

   // ----------------------------------------------------------------------
   // Arithmetic and result select
   // ----------------------------------------------------------------------
   always_comb begin
      cin = carry_i & ((op_i == EMA_OP_ADD_CARRY_TO_ACC) ||
                       (op_i == EMA_OP_ADD_CARRY_TO_MEM));
      low = {1'b0, acc_i[3:0]} + {1'b0, mem_i[3:0]} + {4'h0, cin};
      sum = {1'b0, acc_i} + {1'b0, mem_i} + {{DW{1'b0}}, cin};
      case (op_i)
         EMA_OP_ADD_CARRY_TO_ACC,
         EMA_OP_ADD_CARRY_TO_MEM,
         EMA_OP_ADD_TO_ACC,
         EMA_OP_ADD_TO_MEM: result_o = sum[DW-1:0];
         EMA_OP_AND_TO_ACC,
         EMA_OP_AND_TO_MEM: result_o = acc_i & mem_i;
         EMA_OP_CLEAR_BYTE_OR_BIT: begin
            result_o = bit_mode_i ? (mem_i & keep_mask) : '0;
         end
         default: result_o = mem_i;
      endcase
      c_o    = sum[DW];
      aux_o  = low[4];
      // Signed overflow: like signs in, other sign out
      ovf_o  = (acc_i[DW-1] == mem_i[DW-1]) && (sum[DW-1] != acc_i[DW-1]);
      z_o    = (result_o == '0);
      skip_o = ovf_o ^ result_o[DW-1];
   end
endmodule

// >>> src/ema_dmem.sv
// Sectioned data memory with one write port and asynchronous read
module ema_dmem #(
   parameter int AW = 10,
   parameter int DW = 8
) (
   input  wire logic          clk_i,
   input  wire logic          we_i,
   input  wire logic [AW-1:0] addr_i,
   input  wire logic [DW-1:0] wdata_i,
   output logic      [DW-1:0] rdata_o
);
   // No reset on the array: contents are undefined until software writes
   logic [DW-1:0] mem [2**AW];

   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[addr_i] <= wdata_i;
      end
   end

   assign rdata_o = mem[addr_i];
endmodule

// >>> src/ema_top.sv
// Extended memory ALU instructions with a Wishbone register port
//
// Design decisions made here: the Wishbone interface to the registers and the register addresses.
`include "ema_consts.svh"

module ema_top
   import ema_pkg::*;
#(
   parameter int DW        = 8,
   parameter int SECT_BITS = 2,
   parameter int OFS_BITS  = 8
) (
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   input  wire logic          wb_we_i,
   input  wire logic [7:0]    wb_adr_i,
   input  wire logic [3:0]    wb_sel_i,
   input  wire logic [31:0]   wb_dat_i,
   output logic               wb_ack_o,
   output logic      [31:0]   wb_dat_o
);
   localparam int AW = SECT_BITS + OFS_BITS;

   ema_state_e           state;
   logic [DW-1:0]        accumulator;
   logic                 carry_flag;
   logic                 aux_carry_flag;
   logic                 zero_flag;
   logic                 overflow_flag;
   logic                 skip_condition_flag;
   logic [AW-1:0]        ext_addr;
   logic [SECT_BITS-1:0] bank;
   ema_op_e              op;
   logic                 bit_mode;
   logic [2:0]           bit_sel;
   logic                 bus_req;
   logic                 bus_wr;
   logic                 lane_wr;
   logic [AW-1:0]        mem_addr;
   logic                 mem_we;
   logic [DW-1:0]        mem_wdata;
   logic [DW-1:0]        mem_rdata;
   logic [DW-1:0]        alu_result;
   logic                 alu_c;
   logic                 alu_aux;
   logic                 alu_z;
   logic                 alu_ovf;
   logic                 alu_skip;
   logic                 is_add;
   logic                 is_and;
   logic                 to_acc;
   logic                 exec;
   logic [31:0]          next_rdata;

   // ----------------------------------------------------------------------
   // Wishbone slave decode
   // ----------------------------------------------------------------------
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign bus_wr  = bus_req && wb_we_i;
   assign lane_wr = bus_wr && wb_sel_i[`EMA_LANE0];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_req;
      end
   end

   always_comb begin
      next_rdata = `EMA_RST_WORD;
      case (wb_adr_i)
         `EMA_REG_ACC: next_rdata[DW-1:0] = accumulator;
         `EMA_REG_STATUS: begin
            next_rdata[`EMA_ST_C]    = carry_flag;
            next_rdata[`EMA_ST_AUX]  = aux_carry_flag;
            next_rdata[`EMA_ST_Z]    = zero_flag;
            next_rdata[`EMA_ST_OVF]  = overflow_flag;
            next_rdata[`EMA_ST_SKIP] = skip_condition_flag;
         end
         `EMA_REG_ADDR: next_rdata[AW-1:0] = ext_addr;
         `EMA_REG_BANK: next_rdata[SECT_BITS-1:0] = bank;
         `EMA_REG_CMD: begin
            next_rdata[`EMA_CMD_OP]    = op;
            next_rdata[`EMA_CMD_BITMD] = bit_mode;
            next_rdata[`EMA_CMD_BIT]   = bit_sel;
            next_rdata[`EMA_CMD_BUSY]  = (state == EMA_EXEC);
         end
         `EMA_REG_MDATA: next_rdata[DW-1:0] = mem_rdata;
         default: next_rdata = `EMA_RST_WORD;
      endcase
   end

   // Unmapped addresses are acknowledged and read as zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= `EMA_RST_WORD;
      end else if (bus_req && !wb_we_i) begin
         wb_dat_o <= next_rdata;
      end
   end

   // ----------------------------------------------------------------------
   // Address, bank and command registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_addr <= '0;
      end else if (bus_wr && wb_adr_i == `EMA_REG_ADDR) begin
         ext_addr <= wb_dat_i[AW-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bank <= '0;
      end else if (lane_wr && wb_adr_i == `EMA_REG_BANK) begin
         bank <= wb_dat_i[SECT_BITS-1:0];
      end
   end

   // A command write while busy is dropped; busy lasts one cycle only,
   // which is shorter than any legal gap between two bus cycles
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         op       <= EMA_OP_RESERVED;
         bit_mode <= 1'b0;
         bit_sel  <= '0;
      end else if (lane_wr && wb_adr_i == `EMA_REG_CMD &&
                   state == EMA_IDLE) begin
         op       <= ema_op_e'(wb_dat_i[`EMA_CMD_OP]);
         bit_mode <= wb_dat_i[`EMA_CMD_BITMD];
         bit_sel  <= wb_dat_i[`EMA_CMD_BIT];
      end
   end

   // ----------------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= EMA_IDLE;
      end else begin
         case (state)
            EMA_IDLE: begin
               if (lane_wr && wb_adr_i == `EMA_REG_CMD) begin
                  state <= EMA_EXEC;
               end
            end
            EMA_EXEC: state <= EMA_IDLE;
            default:  state <= EMA_IDLE;
         endcase
      end
   end

   assign exec   = (state == EMA_EXEC);
   assign is_add = (op == EMA_OP_ADD_CARRY_TO_ACC) ||
                   (op == EMA_OP_ADD_CARRY_TO_MEM) ||
                   (op == EMA_OP_ADD_TO_ACC) ||
                   (op == EMA_OP_ADD_TO_MEM);
   assign is_and = (op == EMA_OP_AND_TO_ACC) || (op == EMA_OP_AND_TO_MEM);
   assign to_acc = (op == EMA_OP_ADD_CARRY_TO_ACC) ||
                   (op == EMA_OP_ADD_TO_ACC) ||
                   (op == EMA_OP_AND_TO_ACC);

   // ----------------------------------------------------------------------
   // Datapath
   // ----------------------------------------------------------------------
   // Extended ops take the full address; the bank only serves MDATA
   assign mem_addr = exec ? ext_addr
                          : {bank, ext_addr[OFS_BITS-1:0]};
   assign mem_we   = (exec && !to_acc && op != EMA_OP_RESERVED) ||
                     (!exec && lane_wr && wb_adr_i == `EMA_REG_MDATA);
   assign mem_wdata = exec ? alu_result : wb_dat_i[DW-1:0];

   ema_alu #(
      .DW (DW)
   ) u_alu (
      .acc_i      (accumulator),
      .mem_i      (mem_rdata),
      .carry_i    (carry_flag),
      .op_i       (op),
      .bit_mode_i (bit_mode),
      .bit_i      (bit_sel),
      .result_o   (alu_result),
      .c_o        (alu_c),
      .aux_o      (alu_aux),
      .z_o        (alu_z),
      .ovf_o      (alu_ovf),
      .skip_o     (alu_skip)
   );

   ema_dmem #(
      .AW (AW),
      .DW (DW)
   ) u_dmem (
      .clk_i   (clk_i),
      .we_i    (mem_we),
      .addr_i  (mem_addr),
      .wdata_i (mem_wdata),
      .rdata_o (mem_rdata)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         accumulator <= `EMA_RST_BYTE;
      end else if (exec && to_acc) begin
         accumulator <= alu_result;
      end else if (lane_wr && wb_adr_i == `EMA_REG_ACC) begin
         accumulator <= wb_dat_i[DW-1:0];
      end
   end

   // Flags: adds touch all five, AND only zero, clears none
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {skip_condition_flag, overflow_flag, zero_flag,
          aux_carry_flag, carry_flag} <= `EMA_RST_FLAGS;
      end else if (exec && is_add) begin
         carry_flag          <= alu_c;
         aux_carry_flag      <= alu_aux;
         zero_flag           <= alu_z;
         overflow_flag       <= alu_ovf;
         skip_condition_flag <= alu_skip;
      end else if (exec && is_and) begin
         zero_flag <= alu_z;
      end else if (lane_wr && wb_adr_i == `EMA_REG_STATUS) begin
         carry_flag          <= wb_dat_i[`EMA_ST_C];
         aux_carry_flag      <= wb_dat_i[`EMA_ST_AUX];
         zero_flag           <= wb_dat_i[`EMA_ST_Z];
         overflow_flag       <= wb_dat_i[`EMA_ST_OVF];
         skip_condition_flag <= wb_dat_i[`EMA_ST_SKIP];
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_ext_addr_direct: assert property (
      exec |-> mem_addr == ext_addr)
      else $error("extended op did not use the direct address");

   a_adc_acc_sum: assert property (
      exec && op == EMA_OP_ADD_CARRY_TO_ACC |=>
      {carry_flag, accumulator} == 9'($past(accumulator) +
         $past(mem_rdata) + {8'h00, $past(carry_flag)}))
      else $error("add with carry to accumulator wrong");

   a_adc_mem_sum: assert property (
      exec && op == EMA_OP_ADD_CARRY_TO_MEM |->
      mem_we && mem_wdata == 8'(accumulator + mem_rdata +
         {7'h00, carry_flag}) ##1 $stable(accumulator))
      else $error("add with carry to memory wrong");

   a_add_acc_sum: assert property (
      exec && op == EMA_OP_ADD_TO_ACC |=>
      {carry_flag, accumulator} ==
         9'($past(accumulator) + $past(mem_rdata)))
      else $error("add to accumulator wrong");

   a_add_mem_flags: assert property (
      exec && op == EMA_OP_ADD_TO_MEM |->
      mem_we && mem_wdata == 8'(accumulator + mem_rdata) ##1
      zero_flag == ($past(mem_wdata) == 8'h00) &&
      skip_condition_flag == (overflow_flag ^ $past(mem_wdata[7])))
      else $error("add to memory result or flags wrong");

   a_and_acc_flags: assert property (
      exec && op == EMA_OP_AND_TO_ACC |=>
      accumulator == ($past(accumulator) & $past(mem_rdata)) &&
      $stable(carry_flag) && $stable(overflow_flag) &&
      $stable(aux_carry_flag) && $stable(skip_condition_flag))
      else $error("AND to accumulator wrong");

   a_and_mem_only_z: assert property (
      exec && op == EMA_OP_AND_TO_MEM |->
      mem_we && mem_wdata == (accumulator & mem_rdata) ##1
      $stable(accumulator) && $stable(carry_flag) &&
      zero_flag == ($past(mem_wdata) == 8'h00))
      else $error("AND to memory wrong");

   a_clear_byte_zero: assert property (
      exec && op == EMA_OP_CLEAR_BYTE_OR_BIT && !bit_mode |->
      mem_we && mem_wdata == 8'h00 ##1
      $stable({carry_flag, aux_carry_flag, zero_flag,
               overflow_flag, skip_condition_flag}))
      else $error("byte clear wrong");

   a_clear_bit_one: assert property (
      exec && op == EMA_OP_CLEAR_BYTE_OR_BIT && bit_mode |->
      mem_we && mem_wdata == (mem_rdata & ~(8'h01 << bit_sel)) ##1
      $stable({carry_flag, aux_carry_flag, zero_flag,
               overflow_flag, skip_condition_flag}))
      else $error("bit clear wrong");

   a_ovf_signed: assert property (
      exec && is_add |=> overflow_flag ==
      ($past(accumulator[7]) == $past(mem_rdata[7]) &&
       $past(alu_result[7]) != $past(accumulator[7])))
      else $error("overflow flag wrong");

   a_ack_one_cycle: assert property (
      bus_req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus acknowledge not a single pulse");

   c_adc_acc: cover property (exec && op == EMA_OP_ADD_CARRY_TO_ACC);
   c_add_mem_ovf: cover property (exec && op == EMA_OP_ADD_TO_MEM && alu_ovf);
   c_and_mem_zero: cover property (exec && op == EMA_OP_AND_TO_MEM && alu_z);
   c_clear_bit: cover property (exec && bit_mode &&
                                op == EMA_OP_CLEAR_BYTE_OR_BIT);
endmodule

// >>> tb/ema_wb_master.sv
// Wishbone master standing in for the instruction decoder side
module ema_wb_master (
   input  wire logic        clk_i,
   input  wire logic        ack_i,
   input  wire logic [31:0] dat_i,
   output logic             cyc_o,
   output logic             stb_o,
   output logic             we_o,
   output logic [7:0]       adr_o,
   output logic [3:0]       sel_o,
   output logic [31:0]      dat_o
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o  = 1'b0;
      adr_o = 8'h00;
      sel_o = 4'h0;
      dat_o = 32'h0000_0000;
   end

   // ----------------------------------------------------------------
   // One classic cycle; request held until ack is sampled high
   // ----------------------------------------------------------------
   task automatic xfer(input  logic        we,
                       input  logic [7:0]  a,
                       input  logic [31:0] d,
                       output logic [31:0] q);
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o  <= we;
      adr_o <= a;
      sel_o <= 4'h1;
      dat_o <= d;
      do @(posedge clk_i); while (ack_i !== 1'b1);
      q = dat_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      we_o  <= 1'b0;
      // Idle cycle so the slave can drop ack before the next request
      @(posedge clk_i);
   endtask
endmodule

// >>> tb/tb.sv
// Self-checking bench for the extended memory ALU block
`include "ema_consts.svh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
n_mismatch++; $display("Error %0t: got %h expected %h", $time, got, exp); \
end end

module tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc;
   logic        stb;
   logic        we;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat;
   logic        ack;
   logic [31:0] rdat;
   int          n_mismatch = 0;
   int          tests_run  = 0;
   int          cyc_cnt    = 0;

   always #25 clk_i = ~clk_i;

   ema_wb_master bus (
      .clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
      .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat)
   );

   ema_top #(.DW(8), .SECT_BITS(2), .OFS_BITS(8)) DUT (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_ack_o(ack), .wb_dat_o(rdat)
   );

   // ----------------------------------------------------------------
   // Bus helpers and verdict
   // ----------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus.xfer(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      bus.xfer(1'b0, a, 32'h0000_0000, q);
   endtask

   task automatic end_of_test;
      $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Whole run needs well under 1000 cycles; generous ceiling
   always @(posedge clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 5000) begin
         n_mismatch++;
         end_of_test();
      end
   end

   // ----------------------------------------------------------------
   // Reference: {result, flags} from operands and prior flags
   // ----------------------------------------------------------------
   function automatic logic [12:0] model(logic [2:0] op, logic bm,
      logic [2:0] bn, logic [7:0] a, logic [7:0] m, logic [4:0] st);
      logic       cin;
      logic [8:0] s;
      logic [4:0] h;
      logic [7:0] r;
      logic [4:0] f;
      cin = (op == 3'd0 || op == 3'd1) ? st[0] : 1'b0;
      s = {1'b0, a} + {1'b0, m} + {8'h00, cin};
      h = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, cin};
      f = st;
      r = m;
      if (op <= 3'd3) begin
         r = s[7:0];
         f[0] = s[8];
         f[1] = h[4];
         f[2] = (r == 8'h00);
         f[3] = (a[7] == m[7]) && (r[7] != a[7]);
         f[4] = f[3] ^ r[7];
      end else if (op <= 3'd5) begin
         r = a & m;
         f[2] = (r == 8'h00);
      end else if (op == 3'd6) begin
         r = bm ? (m & ~(8'h01 << bn)) : 8'h00;
      end
      return {r, f};
   endfunction

   // Seeds memory through the banked window, runs with BANK pointing away
   task automatic op_run(input logic [2:0] op, input logic bm,
      input logic [2:0] bn, input logic [7:0] a, input logic [7:0] m,
      input logic [4:0] st, input logic [9:0] ad);
      logic [12:0] e;
      logic [7:0]  ea;
      logic [7:0]  em;
      logic [31:0] q;
      e  = model(op, bm, bn, a, m, st);
      ea = (op inside {3'd0, 3'd2, 3'd4}) ? e[12:5] : a;
      em = (op inside {3'd1, 3'd3, 3'd5, 3'd6}) ? e[12:5] : m;
      wr(`EMA_REG_BANK, {30'h0, ad[9:8]});
      wr(`EMA_REG_ADDR, {22'h0, ad});
      wr(`EMA_REG_MDATA, {24'h00_0000, m});
      wr(`EMA_REG_BANK, {30'h0, ~ad[9:8]});
      wr(`EMA_REG_ACC, {24'h00_0000, a});
      wr(`EMA_REG_STATUS, {27'h0, st});
      wr(`EMA_REG_CMD, {25'h0, bn, bm, op});
      rd(`EMA_REG_CMD, q);
      `CHK(q, {25'h0, bn, bm, op})
      rd(`EMA_REG_ACC, q);
      `CHK(q, {24'h00_0000, ea})
      rd(`EMA_REG_STATUS, q);
      `CHK(q, {27'h0, e[4:0]})
      wr(`EMA_REG_BANK, {30'h0, ad[9:8]});
      rd(`EMA_REG_MDATA, q);
      `CHK(q, {24'h00_0000, em})
      $display("Test op %0d done", op);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] q;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(`EMA_REG_ACC, q);
      `CHK(q, 32'h0000_0000)
      rd(`EMA_REG_STATUS, q);
      `CHK(q, 32'h0000_0000)
      rd(`EMA_REG_ADDR, q);
      `CHK(q, 32'h0000_0000)
      rd(`EMA_REG_BANK, q);
      `CHK(q, 32'h0000_0000)
      rd(`EMA_REG_CMD, q);
      `CHK(q, 32'h0000_0007)
      wr(8'h18, 32'h0000_00FF);
      rd(8'h18, q);
      `CHK(q, 32'h0000_0000)
      $display("Test reset and unmapped done");
      op_run(3'd0, 1'b0, 3'd0, 8'h7F, 8'h00, 5'h01, 10'h037);
      op_run(3'd0, 1'b0, 3'd0, 8'h80, 8'hFF, 5'h00, 10'h0A0);
      op_run(3'd1, 1'b0, 3'd0, 8'hFF, 8'h00, 5'h01, 10'h1FF);
      op_run(3'd2, 1'b0, 3'd0, 8'h80, 8'h80, 5'h01, 10'h200);
      op_run(3'd3, 1'b0, 3'd0, 8'h78, 8'h08, 5'h01, 10'h3A5);
      op_run(3'd4, 1'b0, 3'd0, 8'hF0, 8'h0F, 5'h1B, 10'h111);
      op_run(3'd5, 1'b0, 3'd0, 8'hF0, 8'h0F, 5'h1B, 10'h2C3);
      op_run(3'd6, 1'b0, 3'd0, 8'h3C, 8'hA5, 5'h15, 10'h300);
      op_run(3'd6, 1'b1, 3'd7, 8'h3C, 8'hFF, 5'h0A, 10'h0FE);
      op_run(3'd6, 1'b1, 3'd0, 8'h3C, 8'hFF, 5'h1F, 10'h301);
      op_run(3'd7, 1'b0, 3'd0, 8'h55, 8'hAA, 5'h1F, 10'h155);
      // Mid-run reset must clear what the last test left behind
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(`EMA_REG_ACC, q);
      `CHK(q, 32'h0000_0000)
      rd(`EMA_REG_STATUS, q);
      `CHK(q, 32'h0000_0000)
      rd(`EMA_REG_ADDR, q);
      `CHK(q, 32'h0000_0000)
      $display("Test mid-run reset done");
      end_of_test();
   end
endmodule
